/* File: rtl/ccr_regs.sv */
// Purpose: control registers 2 and 3A-3C of a dual-channel voice codec
// Assumes: register word arrives as address, read/write, data with a strobe
// Notes: shadowed fields are one store seen by both channels
// How it works
// - slow bit clock: 16 x frame x devices x mode
// - fast bit clock: master clock divided by p
// - bypass bit skips decimation and interpolation
// - three address bits head seven-bit host address
// - host pins 00 i2c, 01 alternate two-wire
// - host pins 10: spare bit out, scl routed
// - host pins 11: data pin shows frame flag
// - power-down field selects adc, dac, all
// - soft reset bit resets the control registers, not the bit clock divider or host pins
// - ratio code 1-7 gives n, 0 gives 8
// - voiceband filter enable inserts band-pass filter
// - handset silence bit mutes handset driver
// - headset silence bit mutes headset driver
// - line-out silence bit mutes line driver
// - speaker silence bit mutes speaker driver
// - register 2 fully read-write and shadowed
// - shadowed write updates both channels
// - sub-register index steps and wraps
`timescale 1ns/1ps
`include "ccr_defines.svh"
module ccr_regs #(
  parameter int DIV_W = 16,
  parameter logic [2:0] VERSION_ID = 3'h0 // arbitrary value
) (
  input wire logic core_clk, // 50 MHz clock
  input wire logic rst, // sync reset, high
  input wire logic ce, // clock enable
  input wire logic wr_stb, // register access strobe
  input wire logic wr_chan, // channel addressed
  input wire logic [2:0] reg_addr, // register number
  input wire logic rd_nwr, // 1 read, 0 write
  input wire logic [7:0] wr_data, // control data byte
  output logic [7:0] rd_data, // read data
  output logic rd_valid, // read data valid pulse
  input wire logic [3:0] port_dev_addr, // serial port device address
  input wire logic [2:0] p_code, // divider p from register 4
  input wire logic [3:0] num_devices, // cascaded device count
  input wire logic [1:0] mode_factor, // slot mode factor
  input wire logic [6:0] frame_div, // master cycles per frame slot bit
  input wire logic frame_flag, // control frame flag
  input wire logic proto_sda_o, // two-wire engine data out
  input wire logic proto_sda_oe_n, // two-wire engine enable, low drives
  input wire logic scl_i, // clock pin input
  output logic sda_o, // data pin output
  output logic sda_oe_n, // data pin enable, low drives
  output logic dout_route, // scl input toward serial data out
  output logic dout_route_en, // routing active
  output logic bclk_tick, // serial bit clock tick
  output logic [6:0] host_addr, // seven-bit host address
  output logic alt_two_wire_protocol, // alternate protocol selected
  output logic filters_bypassed, // decimation and interpolation bypass
  output logic [1:0] adc_pd, // adc power-down per channel
  output logic [1:0] dac_pd, // dac power-down per channel
  output logic device_pd, // whole device powered down
  output logic soft_reset, // soft reset pulse
  output logic [7:0] ratio_n0, // sample ratio n, channel 0
  output logic [7:0] ratio_n1, // sample ratio n, channel 1
  output logic [1:0] voiceband_filter_enable, // per channel band-pass
  output logic handset_silence, // handset mute
  output logic headset_silence, // headset mute
  output logic line_out_silence, // line output mute
  output logic speaker_silence // speaker mute
);
  // shadow store for register 2 and for shadowed bits of 3A/3B, beside per-channel 3A-3C fields
  logic [7:0] c2_q, c2_d;
  logic [3:0] mute_q, mute_d;
  logic [1:0] pd_q[2], pd_d[2];
  logic [2:0] rate_ratio_factor_q[2], rate_ratio_factor_d[2];
  logic [1:0] vbf_q, vbf_d;
  logic [1:0] sub_q[2], sub_d[2];
  logic [1:0] c3c_osr_q[2], c3c_osr_d[2];
  logic soft_reset_bit_q, soft_reset_bit_d;
  logic [7:0] rd_q, rd_d;
  logic rv_q, rv_d;
  logic [DIV_W-1:0] slow_div;
  logic wr, rd;

  assign wr = wr_stb && !rd_nwr;
  assign rd = wr_stb && rd_nwr;

  always_comb begin
    c2_d = c2_q;
    mute_d = mute_q;
    vbf_d = vbf_q;
    soft_reset_bit_d = 1'b0;
    rd_d = rd_q;
    rv_d = 1'b0;
    for (int c = 0; c < 2; c++) begin
      pd_d[c] = pd_q[c];
      rate_ratio_factor_d[c] = rate_ratio_factor_q[c];
      sub_d[c] = sub_q[c];
      c3c_osr_d[c] = c3c_osr_q[c];
    end
    if (wr && reg_addr == `CCR_REG_CTRL2) begin
      c2_d = wr_data;
    end
    if (wr && reg_addr == `CCR_REG_CTRL3) begin
      case (wr_data[7:6])
        `CCR_SUB_3A: begin
          pd_d[wr_chan] = wr_data[5:4];
          soft_reset_bit_d = wr_data[`CCR_C3A_SOFT_RESET_BIT];
          rate_ratio_factor_d[wr_chan] = wr_data[2:0];
        end
        `CCR_SUB_3B: begin
          vbf_d[wr_chan] = wr_data[`CCR_C3B_VBF];
          mute_d = wr_data[3:0];
        end
        `CCR_SUB_3C: begin
          c3c_osr_d[wr_chan] = wr_data[1:0];
        end
        default: begin
          c3c_osr_d[wr_chan] = c3c_osr_q[wr_chan];
        end
      endcase
    end
    if (rd) begin
      rv_d = 1'b1;
      if (reg_addr == `CCR_REG_CTRL2) begin
        rd_d = c2_q;
      end else if (reg_addr == `CCR_REG_CTRL3) begin
        case (sub_q[wr_chan])
          `CCR_SUB_3A: rd_d = {2'h0, pd_q[wr_chan], 1'b0, rate_ratio_factor_q[wr_chan]};
          `CCR_SUB_3B: rd_d = {2'h1, 1'b0 | vbf_q[wr_chan], 1'b0, mute_q};
          default: rd_d = {2'h2, 1'b0, VERSION_ID, c3c_osr_q[wr_chan]};
        endcase
        // reads walk the sub-registers; writes name theirs in bits 7:6
        sub_d[wr_chan] = (sub_q[wr_chan] == `CCR_SUB_LAST) ? `CCR_SUB_3A
                         : sub_q[wr_chan] + 2'h1;
      end else begin
        rd_d = 8'h00;
      end
    end
    if (wr && reg_addr == `CCR_REG_CTRL3) begin
      sub_d[wr_chan] = (wr_data[7:6] == `CCR_SUB_LAST) ? `CCR_SUB_3A
                       : wr_data[7:6] + 2'h1;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst || (ce && soft_reset_bit_q)) begin
      c2_q <= `CCR_C2_RESET;
      mute_q <= 4'(`CCR_C3B_RESET);
      vbf_q <= 2'h0;
      soft_reset_bit_q <= 1'b0;
      rd_q <= 8'h00;
      rv_q <= 1'b0;
      for (int c = 0; c < 2; c++) begin
        pd_q[c] <= 2'h0;
        rate_ratio_factor_q[c] <= 3'(`CCR_C3A_RESET);
        sub_q[c] <= `CCR_SUB_3A;
        c3c_osr_q[c] <= 2'h0;
      end
    end else if (ce) begin
      c2_q <= c2_d;
      mute_q <= mute_d;
      vbf_q <= vbf_d;
      soft_reset_bit_q <= soft_reset_bit_d;
      rd_q <= rd_d;
      rv_q <= rv_d;
      for (int c = 0; c < 2; c++) begin
        pd_q[c] <= pd_d[c];
        rate_ratio_factor_q[c] <= rate_ratio_factor_d[c];
        sub_q[c] <= sub_d[c];
        c3c_osr_q[c] <= c3c_osr_d[c];
      end
    end
  end

  // product can reach 16*127*15*3, truncated to DIV_W bits
  assign slow_div = DIV_W'(`CCR_BITS_PER_SLOT * 32'(frame_div) * 32'(num_devices)
                    * 32'(mode_factor));

  ccr_bclk_div #(.CW(DIV_W)) u_div (
    .core_clk(core_clk),
    .rst(rst),
    .ce(ce),
    .turbo(c2_q[`CCR_C2_TURBO]),
    .p_code(p_code),
    .slow_div(slow_div),
    .bclk_tick(bclk_tick)
  );

  ccr_hostpins u_pins (
    .core_clk(core_clk),
    .rst(rst),
    .ce(ce),
    .mode(c2_q[1:0]),
    .spare_bit(c2_q[`CCR_C2_SPARE]),
    .frame_flag(frame_flag),
    .proto_sda_o(proto_sda_o),
    .proto_sda_oe_n(proto_sda_oe_n),
    .scl_i(scl_i),
    .sda_o(sda_o),
    .sda_oe_n(sda_oe_n),
    .dout_route(dout_route),
    .dout_route_en(dout_route_en)
  );

  assign host_addr = {c2_q[`CCR_C2_ADDR_HI:`CCR_C2_ADDR_LO], port_dev_addr};
  assign alt_two_wire_protocol = (c2_q[1:0] == ccr_pkg::CCR_HP_ALT);
  assign filters_bypassed = c2_q[`CCR_C2_BYPASS];
  assign soft_reset = soft_reset_bit_q;
  assign rd_data = rd_q;
  assign rd_valid = rv_q;
  assign voiceband_filter_enable = vbf_q;
  assign handset_silence = mute_q[`CCR_C3B_HNS];
  assign headset_silence = mute_q[`CCR_C3B_HDS];
  assign line_out_silence = mute_q[`CCR_C3B_LNO];
  assign speaker_silence = mute_q[`CCR_C3B_SPK];
  assign ratio_n0 = (rate_ratio_factor_q[0] == 3'h0) ? 8'h08 : {5'h00, rate_ratio_factor_q[0]};
  assign ratio_n1 = (rate_ratio_factor_q[1] == 3'h0) ? 8'h08 : {5'h00, rate_ratio_factor_q[1]};
  assign device_pd = (pd_q[0] == ccr_pkg::CCR_PD_ALL) || (pd_q[1] == ccr_pkg::CCR_PD_ALL);
  assign adc_pd = {pd_q[1] == ccr_pkg::CCR_PD_ADC, pd_q[0] == ccr_pkg::CCR_PD_ADC};
  assign dac_pd = {pd_q[1] == ccr_pkg::CCR_PD_DAC, pd_q[0] == ccr_pkg::CCR_PD_DAC};
endmodule

/* File: rtl/ccr_defines.svh */
// Purpose: offsets, field positions, reset values and timing counts of the control bank
// Assumes: registers addressed by the 3-bit register number of the control word
// Notes: sub-registers of register 3 are chosen by data bits 7:6 on writes, by a stepping index on reads
`ifndef CCR_DEFINES_SVH
`define CCR_DEFINES_SVH
`define CCR_REG_CTRL2 3'h2
`define CCR_REG_CTRL3 3'h3
`define CCR_SUB_3A 2'h0
`define CCR_SUB_3B 2'h1
`define CCR_SUB_3C 2'h2
`define CCR_SUB_LAST 2'h2
`define CCR_C2_TURBO 7
`define CCR_C2_BYPASS 6
`define CCR_C2_ADDR_HI 5
`define CCR_C2_ADDR_LO 3
`define CCR_C2_SPARE 2
`define CCR_C3A_SOFT_RESET_BIT 3
`define CCR_C3B_VBF 5
`define CCR_C3B_HNS 3
`define CCR_C3B_HDS 2
`define CCR_C3B_LNO 1
`define CCR_C3B_SPK 0
`define CCR_C2_RESET 8'h20
`define CCR_C3A_RESET 6'h01
`define CCR_C3B_RESET 6'h00
`define CCR_C3C_RESET 6'h00
`define CCR_BITS_PER_SLOT 16
`endif

/* File: rtl/ccr_pkg.sv */
// Purpose: shared types of the control bank
// Assumes: nothing
// Notes: host pin modes and power-down codes
package ccr_pkg;
  typedef enum logic [1:0] {
    CCR_HP_I2C = 2'h0,
    CCR_HP_ALT = 2'h1,
    CCR_HP_SPARE = 2'h2,
    CCR_HP_FLAG = 2'h3
  } ccr_hostpin_t;
  typedef enum logic [1:0] {
    CCR_PD_NONE = 2'h0,
    CCR_PD_ADC = 2'h1,
    CCR_PD_DAC = 2'h2,
    CCR_PD_ALL = 2'h3
  } ccr_pdsel_t;
endpackage

/* File: rtl/ccr_bclk_div.sv */
// Purpose: serial bit clock enable generator
// Assumes: core_clk stands in for the master clock
// Notes: emits a one-cycle tick per bit clock period
`timescale 1ns/1ps
`include "ccr_defines.svh"
module ccr_bclk_div #(
  parameter int CW = 16
) (
  input wire logic core_clk, // master clock
  input wire logic rst, // sync reset
  input wire logic ce, // clock enable
  input wire logic turbo, // fast mode select
  input wire logic [2:0] p_code, // divider p, 0 means 8
  input wire logic [CW-1:0] slow_div, // slow mode period in cycles
  output logic bclk_tick // bit clock tick
);
  logic [CW-1:0] cnt_q, cnt_d, period;
  logic tick_d, tick_q;
  always_comb begin
    if (turbo) begin
      period = (p_code == 3'h0) ? CW'(8) : CW'(p_code);
    end else begin
      period = (slow_div == '0) ? CW'(1) : slow_div;
    end
    tick_d = 1'b0;
    cnt_d = cnt_q + CW'(1);
    if (cnt_q + CW'(1) >= period) begin
      cnt_d = '0;
      tick_d = 1'b1;
    end
  end
  always_ff @(posedge core_clk) begin
    if (rst) begin
      cnt_q <= '0;
      tick_q <= 1'b0;
    end else if (ce) begin
      cnt_q <= cnt_d;
      tick_q <= tick_d;
    end
  end
  assign bclk_tick = tick_q;
endmodule

/* File: rtl/ccr_hostpins.sv */
// Purpose: host pin steering by configuration field
// Assumes: pins are open-drain style, enable low means driven
// Notes: in two-wire modes the protocol engine owns the data pin
`timescale 1ns/1ps
module ccr_hostpins (
  input wire logic core_clk, // clock
  input wire logic rst, // sync reset
  input wire logic ce, // clock enable
  input wire logic [1:0] mode, // host pin configuration
  input wire logic spare_bit, // spare output bit
  input wire logic frame_flag, // control frame flag
  input wire logic proto_sda_o, // protocol engine data out
  input wire logic proto_sda_oe_n, // protocol engine data enable, low drives
  input wire logic scl_i, // clock pin input
  output logic sda_o, // data pin output
  output logic sda_oe_n, // data pin enable, low drives
  output logic dout_route, // scl level routed to serial data out
  output logic dout_route_en // routing active
);
  logic o_d, oe_d, r_d, re_d, o_q, oe_q, r_q, re_q;
  always_comb begin
    o_d = proto_sda_o;
    oe_d = proto_sda_oe_n;
    r_d = 1'b0;
    re_d = 1'b0;
    case (ccr_pkg::ccr_hostpin_t'(mode))
      ccr_pkg::CCR_HP_I2C, ccr_pkg::CCR_HP_ALT: begin
        o_d = proto_sda_o;
        oe_d = proto_sda_oe_n;
      end
      ccr_pkg::CCR_HP_SPARE: begin
        o_d = spare_bit;
        oe_d = 1'b0;
        r_d = scl_i;
        re_d = 1'b1;
      end
      ccr_pkg::CCR_HP_FLAG: begin
        o_d = frame_flag;
        oe_d = 1'b0;
      end
      default: begin
        o_d = proto_sda_o;
      end
    endcase
  end
  always_ff @(posedge core_clk) begin
    if (rst) begin
      o_q <= 1'b1;
      oe_q <= 1'b1;
      r_q <= 1'b0;
      re_q <= 1'b0;
    end else if (ce) begin
      o_q <= o_d;
      oe_q <= oe_d;
      r_q <= r_d;
      re_q <= re_d;
    end
  end
  assign sda_o = o_q;
  assign sda_oe_n = oe_q;
  assign dout_route = r_q;
  assign dout_route_en = re_q;
endmodule

/* File: test/ccr_regs_props.sv */
// Purpose: port checker of the control bank
// Assumes: one clock, sync reset, strobe taken on ce
// Notes: bound onto every ccr_regs
`timescale 1ns/1ps
module ccr_regs_props (
  input wire logic core_clk, // clock
  input wire logic rst, // reset
  input wire logic ce, // enable
  input wire logic wr_stb, // strobe
  input wire logic wr_chan, // channel
  input wire logic [2:0] reg_addr, // register
  input wire logic rd_nwr, // read select
  input wire logic [7:0] wr_data, // data
  input wire logic rd_valid, // read valid
  input wire logic [6:0] host_addr, // host address
  input wire logic filters_bypassed, // bypass
  input wire logic [1:0] adc_pd, // adc off
  input wire logic soft_reset, // soft reset
  input wire logic [7:0] ratio_n0, // ratio
  input wire logic handset_silence, // mute
  input wire logic headset_silence, // mute
  input wire logic line_out_silence, // mute
  input wire logic speaker_silence // mute
);
  logic wr2;
  logic wr3;
  assign wr2 = ce && wr_stb && !rd_nwr && reg_addr == 3'h2;
  assign wr3 = ce && wr_stb && !rd_nwr && reg_addr == 3'h3;
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  chk_read_answer: assert property (ce && wr_stb && rd_nwr |=> rd_valid)
    else $error("read not answered");
  chk_reset_addr: assert property ($fell(rst) |-> host_addr[6:4] == 3'h4)
    else $error("address bits not 100");
  chk_soft_reset_bit_pulse: assert property (wr3 && wr_data[7:6] == 2'h0 && wr_data[3]
    |-> ##[1:2] soft_reset)
    else $error("no soft reset pulse");
  chk_soft_reset_bit_clear: assert property (soft_reset |-> ##[1:2] host_addr[6:4] == 3'h4)
    else $error("soft reset left bank");
  chk_bypass_write: assert property (wr2 |=> filters_bypassed == $past(wr_data[6]))
    else $error("bypass wrong");
  chk_ratio_write: assert property (wr3 && wr_data[7:6] == 2'h0 && !wr_chan
    |=> ratio_n0 == ($past(wr_data[2:0]) == 3'h0 ? 8'h08 : {5'h00, $past(wr_data[2:0])}))
    else $error("ratio wrong");
  chk_mute_write: assert property (wr3 && wr_data[7:6] == 2'h1
    |=> {handset_silence, headset_silence, line_out_silence, speaker_silence}
    == $past(wr_data[3:0]))
    else $error("mute wrong");
  chk_adc_off: assert property (wr3 && wr_data[7:5] == 3'h0
    |=> adc_pd[$past(wr_chan)] == $past(wr_data[4]))
    else $error("adc power-down wrong");
  cover property (wr3 && wr_data[7:6] == 2'h1);
  cover property (soft_reset);
  cover property (rd_valid);
endmodule
bind ccr_regs ccr_regs_props ccr_regs_props_inst (.*);

/* File: test/ccr_host_model.sv */
// Purpose: host model issuing control words
// Assumes: strobe taken on one edge, read answered on that same edge
// Notes: data lines show the inverse of the last word when idle
`timescale 1ns/1ps
module ccr_host_model (
  input wire logic core_clk, // clock
  input wire logic rd_valid, // read valid
  input wire logic [7:0] rd_data, // read data
  output logic wr_stb, // strobe
  output logic wr_chan, // channel
  output logic [2:0] reg_addr, // register
  output logic rd_nwr, // read select
  output logic [7:0] wr_data // data
);
  logic got_valid;
  logic [7:0] last_rd;
  initial begin
    wr_stb = 1'b0;
    wr_chan = 1'b0;
    reg_addr = 3'h0;
    rd_nwr = 1'b1;
    wr_data = 8'hFF;
  end
  // one register access: strobe held for one cycle, then read valid and read data sampled
  task access(input logic ch, input logic [2:0] ad, input logic rw, input logic [7:0] d);
    @(posedge core_clk);
    #1;
    wr_stb = 1'b1;
    wr_chan = ch;
    reg_addr = ad;
    rd_nwr = rw;
    wr_data = d;
    @(posedge core_clk);
    #1;
    wr_stb = 1'b0;
    wr_data = ~d;
    got_valid = rd_valid;
    last_rd = rd_data;
  endtask
endmodule

/* File: test/ccr_regs_bench.sv */
// Purpose: self-checking bench of the control bank
// Assumes: host model drives the register word
// Notes: bit clock kept short through small level inputs
`timescale 1ns/1ps
module ccr_regs_bench;
  logic core_clk, rst, ce, frame_flag, proto_sda_o, proto_sda_oe_n, scl_i;
  logic [3:0] port_dev_addr, num_devices;
  logic [2:0] p_code, reg_addr;
  logic [1:0] mode_factor, adc_pd, dac_pd, voiceband_filter_enable;
  logic [6:0] frame_div, host_addr;
  logic [7:0] wr_data, rd_data, ratio_n0, ratio_n1;
  logic wr_stb, wr_chan, rd_nwr, rd_valid, sda_o, sda_oe_n, dout_route, dout_route_en;
  logic bclk_tick, alt_two_wire_protocol, filters_bypassed, device_pd, soft_reset;
  logic handset_silence, headset_silence, line_out_silence, speaker_silence;
  int err_count, comparisons, i;
  ccr_regs ccr_regs_inst (.*);
  ccr_host_model ccr_host_model_inst (.*);
  always #10 core_clk = ~core_clk;
  task cmp(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp) begin
      err_count++;
      $display("Error %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task finish_test;
    $display("comparisons %0d mismatches %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task wr(input logic ch, input logic [2:0] ad, input logic [7:0] d);
    ccr_host_model_inst.access(ch, ad, 1'b0, d);
  endtask
  task rd(input logic ch, input logic [2:0] ad, input logic [7:0] exp);
    ccr_host_model_inst.access(ch, ad, 1'b1, 8'h00);
    cmp({7'h00, ccr_host_model_inst.got_valid}, 8'h01);
    cmp(ccr_host_model_inst.last_rd, exp);
  endtask
  task settle;
    repeat (2) @(posedge core_clk);
    #1;
  endtask
  // tick spacing in cycles; the first tick seen may still belong to the old mode
  task gap(input logic [7:0] exp);
    int n;
    int m;
    for (n = 0; n < 300 && bclk_tick !== 1'b1; n++) begin
      @(posedge core_clk);
      #1;
    end
    m = 0;
    do begin
      @(posedge core_clk);
      #1;
      m++;
    end while (m < 300 && bclk_tick !== 1'b1);
    if (n >= 300 || m >= 300) begin
      err_count++;
      $display("Error %0t: bit clock tick missing", $time);
      finish_test;
    end else begin
      cmp(m[7:0], exp);
    end
  endtask
  task t_regs;
    rd(1'b0, 3'h2, 8'h20);
    cmp({1'b0, host_addr}, {4'h4, port_dev_addr});
    wr(1'b0, 3'h2, 8'h4D);
    rd(1'b1, 3'h2, 8'h4D);
    cmp({6'h00, filters_bypassed, alt_two_wire_protocol}, 8'h03);
    cmp({1'b0, host_addr}, {4'h1, port_dev_addr});
    rd(1'b0, 3'h5, 8'h00);
    // with the clock enable low the write must be lost
    ce = 1'b0;
    wr(1'b0, 3'h2, 8'h00);
    ce = 1'b1;
    rd(1'b0, 3'h2, 8'h4D);
    $display("register 2 test done");
  endtask
  task t_pins;
    scl_i = 1'b0;
    wr(1'b0, 3'h2, 8'h26);
    settle;
    cmp({4'h0, sda_o, sda_oe_n, dout_route, dout_route_en}, 8'h09);
    scl_i = 1'b1;
    settle;
    cmp({7'h00, dout_route}, 8'h01);
    frame_flag = 1'b1;
    wr(1'b1, 3'h2, 8'h23);
    settle;
    cmp({6'h00, sda_o, sda_oe_n}, 8'h02);
    proto_sda_o = 1'b0;
    proto_sda_oe_n = 1'b0;
    wr(1'b0, 3'h2, 8'h20);
    settle;
    cmp({5'h00, filters_bypassed, sda_o, sda_oe_n}, 8'h00);
    $display("host pin test done");
  endtask
  task t_sub3;
    for (i = 0; i < 8; i++) begin
      wr(1'b0, 3'h3, {5'h00, i[2:0]});
      cmp(ratio_n0, i == 0 ? 8'h08 : i[7:0]);
    end
    for (i = 0; i < 4; i++) begin
      wr(1'b1, 3'h3, {2'h0, i[1:0], 4'h5});
      cmp({7'h00, device_pd}, {7'h00, i == 3});
      if (i < 3) cmp({6'h00, adc_pd[1], dac_pd[1]}, {6'h00, i == 1, i == 2});
    end
    cmp(ratio_n1, 8'h05);
    cmp(ratio_n0, 8'h07);
    for (i = 0; i < 4; i++) begin
      wr(1'b1, 3'h3, {4'h6, 4'h1 << i});
      cmp({handset_silence, headset_silence, line_out_silence, speaker_silence,
        voiceband_filter_enable, 2'h0}, {4'h1 << i, 4'h8});
    end
    wr(1'b1, 3'h3, 8'h82);
    rd(1'b1, 3'h3, 8'h35);
    rd(1'b1, 3'h3, 8'h68);
    rd(1'b1, 3'h3, 8'h82);
    rd(1'b1, 3'h3, 8'h35);
    $display("register 3 test done");
  endtask
  task t_clock;
    wr(1'b0, 3'h2, 8'hA0);
    gap(8'h03);
    num_devices = 4'h2;
    wr(1'b0, 3'h2, 8'h20);
    gap(8'h20);
    wr(1'b0, 3'h2, 8'h4D);
    wr(1'b0, 3'h3, 8'h08);
    cmp({7'h00, soft_reset}, 8'h01);
    settle;
    rd(1'b1, 3'h2, 8'h20);
    cmp(ratio_n1, 8'h01);
    cmp({handset_silence, headset_silence, line_out_silence, speaker_silence,
      voiceband_filter_enable, device_pd, 1'b0}, 8'h00);
    $display("clock and soft reset test done");
  endtask
  initial begin
    core_clk = 1'b0;
    rst = 1'b1;
    ce = 1'b1;
    frame_flag = 1'b0;
    proto_sda_o = 1'b1;
    proto_sda_oe_n = 1'b1;
    scl_i = 1'b1;
    port_dev_addr = 4'h9;
    p_code = 3'h3;
    num_devices = 4'h1;
    mode_factor = 2'h1;
    frame_div = 7'h01;
    err_count = 0;
    comparisons = 0;
    repeat (20) @(posedge core_clk);
    #1;
    rst = 1'b0;
    t_regs;
    t_pins;
    t_sub3;
    t_clock;
    finish_test;
  end
endmodule
